// file: pkg/pfmsc_regs.vh
`ifndef PFMSC_REGS_VH
`define PFMSC_REGS_VH

// ========================================
// register map
`define PFMSC_ADDR_CTRL 6'h00
`define PFMSC_ADDR_FUNC 6'h01
`define PFMSC_ADDR_GOUT 6'h02
`define PFMSC_ADDR_GOE 6'h03
`define PFMSC_ADDR_GIN 6'h04
`define PFMSC_ADDR_STRAP 6'h05
`define PFMSC_RESP_OKAY 2'h0
`define PFMSC_RESP_SLVERR 2'h2

// ========================================
// control fields and reset values
`define PFMSC_CTRL_SDIO4 0
`define PFMSC_CTRL_RDWAIT 1
`define PFMSC_CTRL_CENTRAL 2
`define PFMSC_CTRL_I2S 3
`define PFMSC_CTRL_MCLK 4
`define PFMSC_CTRL_XOSC 5
`define PFMSC_CTRL_OSCON 6
`define PFMSC_CTRL_RST 32'h00000041
`define PFMSC_FUNC_RST 32'h00000000
`define PFMSC_GOUT_RST 32'h00000000
`define PFMSC_GOE_RST 32'h00000000

// ========================================
// straps
`define PFMSC_STRAP_RST 8'hff
`define PFMSC_STRAP_REFCLK 5
`define PFMSC_STRAP_SETTLE 3'h4

// ========================================
// pad map
`define PFMSC_ALT_OUT_MASK 32'h842a4a29
`define PFMSC_PAD_OSC 0
`define PFMSC_PAD_RST_W 1
`define PFMSC_PAD_RST_B 2
`define PFMSC_PAD_MCLK 3
`define PFMSC_PAD_BCLK 4
`define PFMSC_PAD_DOUT 5
`define PFMSC_PAD_DIN 6
`define PFMSC_PAD_SYNC 7
`define PFMSC_PAD_CTS 8
`define PFMSC_PAD_RTS 9
`define PFMSC_PAD_RX 10
`define PFMSC_PAD_TX 11
`define PFMSC_PAD_DIR 12
`define PFMSC_PAD_REQ 13
`define PFMSC_PAD_GNT 14
`define PFMSC_PAD_PRI 15
`define PFMSC_PAD_WWAKE_IN 16
`define PFMSC_PAD_WWAKE_OUT 17
`define PFMSC_PAD_BWAKE_IN 18
`define PFMSC_PAD_BWAKE_OUT 19
`define PFMSC_PAD_OVERLAP 20
`define PFMSC_PAD_IRQ 21
`define PFMSC_PAD_SER_IN 25
`define PFMSC_PAD_SER_OUT 26
`define PFMSC_PAD_TCK 28
`define PFMSC_PAD_TMS 29
`define PFMSC_PAD_TDI 30
`define PFMSC_PAD_TDO 31

`endif

// file: hdl/pfmsc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "pfmsc_regs.vh"

module pfmsc_top (
  input wire CLOCK,
  input wire SYS_RST,
  input wire [7:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  input wire [7:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  input wire FULL_POWERDOWN_N,
  input wire [1:0] HOST_BOOT_PAD,
  input wire FRONT_END_CTRL_LINE3_I,
  output reg FRONT_END_CTRL_LINE3_O,
  output reg FRONT_END_CTRL_LINE3_OE_N,
  input wire FRONT_END_CTRL_LINE4_I,
  output reg FRONT_END_CTRL_LINE4_O,
  output reg FRONT_END_CTRL_LINE4_OE_N,
  input wire [31:0] GPIO_PAD_I,
  output reg [31:0] GPIO_PAD_O,
  output reg [31:0] GPIO_PAD_OE_N,
  input wire [3:0] SD_DAT_PAD_I,
  output reg [3:0] SD_DAT_PAD_O,
  output reg [3:0] SD_DAT_PAD_OE_N,
  input wire FRONT_END_CTRL_LINE3,
  input wire FRONT_END_CTRL_LINE4,
  input wire [3:0] SD_DAT_OUT,
  input wire [3:0] SD_DAT_OUT_EN,
  input wire SDIO_DATA2_READWAIT,
  input wire SDIO_DATA1_IRQ,
  input wire HOST_IRQ_OUT,
  input wire UART_TX,
  input wire UART_RTS_N,
  input wire AUD_PCM_CLK,
  input wire AUD_I2S_BCLK,
  input wire AUD_SYNC_OUT,
  input wire AUD_DOUT,
  input wire COEX_GRANT_OUT,
  input wire COEX_SERIAL_OUT,
  input wire RADIO_B_WAKE_OUT,
  input wire RADIO_W_WAKE_OUT,
  input wire JTAG_TDO,
  output reg [3:0] SD_DAT_IN,
  output reg UART_RX,
  output reg UART_CTS_N,
  output reg AUD_BCLK_IN,
  output reg AUD_SYNC_IN,
  output reg AUD_DIN,
  output reg COEX_DIR_IN,
  output reg COEX_REQUEST_IN,
  output reg COEX_PRIORITY_IN,
  output reg COEX_OVERLAP_IN,
  output reg COEX_SERIAL_IN,
  output reg RADIO_B_WAKE_IN,
  output reg RADIO_W_WAKE_IN,
  output reg RADIO_B_RESET_IN,
  output reg RADIO_W_RESET_IN,
  output reg JTAG_TCK,
  output reg JTAG_TMS,
  output reg JTAG_TDI,
  output wire REFCLK_40MHZ,
  output wire [1:0] HOST_IF_SEL,
  output wire STRAP_DONE,
  output wire POWERDOWN
);

  localparam ST_WAIT = 2'h0;
  localparam ST_CAPT = 2'h1;
  localparam ST_DONE = 2'h2;

  // ========================================
  // pin synchronisers
  reg [40:0] in_s1;
  reg [40:0] in_s2;
  wire [31:0] gpio_s;
  wire [3:0] sd_s;
  wire fe3_s;
  wire fe4_s;
  wire [1:0] boot_s;
  wire pd;

  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      in_s1 <= 41'h0;
      in_s2 <= 41'h0;
    end else begin
      in_s1 <= {FULL_POWERDOWN_N, HOST_BOOT_PAD, FRONT_END_CTRL_LINE4_I, FRONT_END_CTRL_LINE3_I,
                SD_DAT_PAD_I, GPIO_PAD_I};
      in_s2 <= in_s1;
    end
  end

  assign gpio_s = in_s2[31:0];
  assign sd_s = in_s2[35:32];
  assign fe3_s = in_s2[36];
  assign fe4_s = in_s2[37];
  assign boot_s = in_s2[39:38];
  // floating pin is pulled low on the board side, so it reads as power-down
  assign pd = ~in_s2[40];

  // ========================================
  // registers
  reg [31:0] ctrl;
  reg [31:0] func;
  reg [31:0] gout;
  reg [31:0] goe;
  reg [7:0] strap_bits;
  reg [1:0] state;
  reg [2:0] settle;
  reg pd_q;
  reg [5:0] aw_idx;
  reg aw_got;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_got;
  reg codec_main_clock_alt;

  reg done;
  wire central;
  wire i2s;
  wire xosc;
  wire [31:0] alt_en;
  wire [31:0] alt_drive;
  wire [5:0] ar_idx;

  assign central = ctrl[`PFMSC_CTRL_CENTRAL];
  assign i2s = ctrl[`PFMSC_CTRL_I2S];
  assign xosc = ctrl[`PFMSC_CTRL_XOSC];
  // pad 0 may only turn to the oscillator enable with an external oscillator
  assign alt_en = func & {31'h7fffffff, xosc};
  assign alt_drive = `PFMSC_ALT_OUT_MASK | {24'h0, central, 2'h0, central, 4'h0};
  assign ar_idx = ARADDR[7:2];
  assign REFCLK_40MHZ = strap_bits[`PFMSC_STRAP_REFCLK];
  assign HOST_IF_SEL = strap_bits[1:0];
  // status pin taken from its own flop, never from a state decode
  assign STRAP_DONE = done;
  assign POWERDOWN = pd_q;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // ========================================
  // strap capture
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      state <= ST_WAIT;
      settle <= 3'h0;
      strap_bits <= `PFMSC_STRAP_RST;
      pd_q <= 1'b1;
      done <= 1'b0;
    end else begin
      pd_q <= pd;
      if (pd) begin
        // power-down release counts as a fresh start for the straps
        state <= ST_WAIT;
        settle <= 3'h0;
        done <= 1'b0;
      end else begin
        case (state)
          ST_WAIT: begin
            settle <= settle + 3'h1;
            if (settle == `PFMSC_STRAP_SETTLE) begin
              state <= ST_CAPT;
            end
          end
          ST_CAPT: begin
            // unprinted bits keep the pulled-up value
            strap_bits <= {fe4_s, 1'b1, fe3_s, 3'h7, boot_s};
            state <= ST_DONE;
            done <= 1'b1;
          end
          ST_DONE: begin
            state <= ST_DONE;
          end
          default: begin
            state <= ST_WAIT;
            done <= 1'b0;
          end
        endcase
      end
    end
  end

  // ========================================
  // pad muxing
  reg [31:0] alt_val;
  reg [31:0] next_gpio_o;
  reg [31:0] next_gpio_oe_n;
  reg [3:0] next_sd_o;
  reg [3:0] next_sd_oe_n;

  always @* begin
    alt_val = 32'h0;
    alt_val[`PFMSC_PAD_OSC] = ctrl[`PFMSC_CTRL_OSCON];
    alt_val[`PFMSC_PAD_MCLK] = codec_main_clock_alt;
    alt_val[`PFMSC_PAD_BCLK] = i2s ? AUD_I2S_BCLK : AUD_PCM_CLK;
    alt_val[`PFMSC_PAD_DOUT] = AUD_DOUT;
    alt_val[`PFMSC_PAD_SYNC] = AUD_SYNC_OUT;
    alt_val[`PFMSC_PAD_RTS] = UART_RTS_N;
    alt_val[`PFMSC_PAD_TX] = UART_TX;
    alt_val[`PFMSC_PAD_GNT] = COEX_GRANT_OUT;
    alt_val[`PFMSC_PAD_WWAKE_OUT] = RADIO_W_WAKE_OUT;
    alt_val[`PFMSC_PAD_BWAKE_OUT] = RADIO_B_WAKE_OUT;
    alt_val[`PFMSC_PAD_IRQ] = HOST_IRQ_OUT;
    alt_val[`PFMSC_PAD_SER_OUT] = COEX_SERIAL_OUT;
    alt_val[`PFMSC_PAD_TDO] = JTAG_TDO;
    // each pad has exactly one source: its function or the general-purpose path
    next_gpio_o = (alt_en & alt_val) | (~alt_en & gout);
    next_gpio_oe_n = ~((alt_en & alt_drive) | (~alt_en & goe));
    if (pd) begin
      next_gpio_o = 32'h0;
      next_gpio_oe_n = 32'hffffffff;
      // oscillator stays off through power-down
      next_gpio_oe_n[`PFMSC_PAD_OSC] = ~alt_en[`PFMSC_PAD_OSC];
    end
    next_sd_o = SD_DAT_OUT;
    next_sd_oe_n = ~SD_DAT_OUT_EN;
    if (ctrl[`PFMSC_CTRL_RDWAIT] && SDIO_DATA2_READWAIT) begin
      next_sd_o[2] = 1'b0;
      next_sd_oe_n[2] = 1'b0;
    end
    if (!ctrl[`PFMSC_CTRL_SDIO4]) begin
      // one-bit mode: data1 signals the interrupt low, data3 unused
      next_sd_o[1] = 1'b0;
      next_sd_oe_n[1] = ~SDIO_DATA1_IRQ;
      next_sd_o[3] = 1'b0;
      next_sd_oe_n[3] = 1'b1;
    end
  end

  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      GPIO_PAD_O <= 32'h0;
      GPIO_PAD_OE_N <= 32'hffffffff;
      SD_DAT_PAD_O <= 4'h0;
      SD_DAT_PAD_OE_N <= 4'hf;
      FRONT_END_CTRL_LINE3_O <= 1'b0;
      FRONT_END_CTRL_LINE3_OE_N <= 1'b1;
      FRONT_END_CTRL_LINE4_O <= 1'b0;
      FRONT_END_CTRL_LINE4_OE_N <= 1'b1;
      codec_main_clock_alt <= 1'b0;
    end else begin
      GPIO_PAD_O <= next_gpio_o;
      GPIO_PAD_OE_N <= next_gpio_oe_n;
      SD_DAT_PAD_O <= next_sd_o;
      SD_DAT_PAD_OE_N <= next_sd_oe_n;
      // in peripheral mode the codec clock follows the incoming bit clock
      codec_main_clock_alt <= ctrl[`PFMSC_CTRL_MCLK] &
                              (central ? (i2s ? AUD_I2S_BCLK : AUD_PCM_CLK) : gpio_s[`PFMSC_PAD_BCLK]);
      if (pd) begin
        FRONT_END_CTRL_LINE3_O <= 1'b1;
        FRONT_END_CTRL_LINE3_OE_N <= 1'b0;
        FRONT_END_CTRL_LINE4_O <= 1'b0;
        FRONT_END_CTRL_LINE4_OE_N <= 1'b0;
      end else begin
        // released until captured, so the internal pull-up gives one
        FRONT_END_CTRL_LINE3_O <= done & FRONT_END_CTRL_LINE3;
        FRONT_END_CTRL_LINE3_OE_N <= ~done;
        FRONT_END_CTRL_LINE4_O <= done & FRONT_END_CTRL_LINE4;
        FRONT_END_CTRL_LINE4_OE_N <= ~done;
      end
    end
  end

  // ========================================
  // pad inputs toward the core
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      SD_DAT_IN <= 4'hf;
      UART_RX <= 1'b1;
      UART_CTS_N <= 1'b1;
      AUD_BCLK_IN <= 1'b0;
      AUD_SYNC_IN <= 1'b0;
      AUD_DIN <= 1'b0;
      COEX_DIR_IN <= 1'b0;
      COEX_REQUEST_IN <= 1'b0;
      COEX_PRIORITY_IN <= 1'b0;
      COEX_OVERLAP_IN <= 1'b0;
      COEX_SERIAL_IN <= 1'b1;
      RADIO_B_WAKE_IN <= 1'b0;
      RADIO_W_WAKE_IN <= 1'b0;
      RADIO_B_RESET_IN <= 1'b0;
      RADIO_W_RESET_IN <= 1'b0;
      JTAG_TCK <= 1'b0;
      JTAG_TMS <= 1'b1;
      JTAG_TDI <= 1'b1;
    end else begin
      SD_DAT_IN <= sd_s;
      UART_RX <= alt_en[`PFMSC_PAD_RX] ? gpio_s[`PFMSC_PAD_RX] : 1'b1;
      UART_CTS_N <= alt_en[`PFMSC_PAD_CTS] ? gpio_s[`PFMSC_PAD_CTS] : 1'b1;
      AUD_BCLK_IN <= alt_en[`PFMSC_PAD_BCLK] & ~central & gpio_s[`PFMSC_PAD_BCLK];
      AUD_SYNC_IN <= alt_en[`PFMSC_PAD_SYNC] & ~central & gpio_s[`PFMSC_PAD_SYNC];
      AUD_DIN <= alt_en[`PFMSC_PAD_DIN] & gpio_s[`PFMSC_PAD_DIN];
      COEX_DIR_IN <= alt_en[`PFMSC_PAD_DIR] & gpio_s[`PFMSC_PAD_DIR];
      COEX_REQUEST_IN <= alt_en[`PFMSC_PAD_REQ] & gpio_s[`PFMSC_PAD_REQ];
      COEX_PRIORITY_IN <= alt_en[`PFMSC_PAD_PRI] & gpio_s[`PFMSC_PAD_PRI];
      COEX_OVERLAP_IN <= alt_en[`PFMSC_PAD_OVERLAP] & gpio_s[`PFMSC_PAD_OVERLAP];
      COEX_SERIAL_IN <= alt_en[`PFMSC_PAD_SER_IN] ? gpio_s[`PFMSC_PAD_SER_IN] : 1'b1;
      RADIO_B_WAKE_IN <= alt_en[`PFMSC_PAD_BWAKE_IN] & gpio_s[`PFMSC_PAD_BWAKE_IN];
      RADIO_W_WAKE_IN <= alt_en[`PFMSC_PAD_WWAKE_IN] & gpio_s[`PFMSC_PAD_WWAKE_IN];
      RADIO_B_RESET_IN <= alt_en[`PFMSC_PAD_RST_B] & gpio_s[`PFMSC_PAD_RST_B];
      RADIO_W_RESET_IN <= alt_en[`PFMSC_PAD_RST_W] & gpio_s[`PFMSC_PAD_RST_W];
      JTAG_TCK <= alt_en[`PFMSC_PAD_TCK] & gpio_s[`PFMSC_PAD_TCK];
      JTAG_TMS <= alt_en[`PFMSC_PAD_TMS] ? gpio_s[`PFMSC_PAD_TMS] : 1'b1;
      JTAG_TDI <= alt_en[`PFMSC_PAD_TDI] ? gpio_s[`PFMSC_PAD_TDI] : 1'b1;
    end
  end

  // ========================================
  // register bus slave
  // one transfer per direction at a time; ready drops until the answer is taken
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= `PFMSC_RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_idx <= 6'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      ctrl <= `PFMSC_CTRL_RST;
      func <= `PFMSC_FUNC_RST;
      gout <= `PFMSC_GOUT_RST;
      goe <= `PFMSC_GOE_RST;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_idx <= AWADDR[7:2];
        aw_got <= 1'b1;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_data <= WDATA;
        w_strb <= WSTRB;
        w_got <= 1'b1;
        WREADY <= 1'b0;
      end
      if (aw_got && w_got && !BVALID) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= `PFMSC_RESP_OKAY;
        case (aw_idx)
          `PFMSC_ADDR_CTRL: ctrl <= merge(ctrl, w_data, w_strb) & 32'h0000007f;
          `PFMSC_ADDR_FUNC: func <= merge(func, w_data, w_strb);
          `PFMSC_ADDR_GOUT: gout <= merge(gout, w_data, w_strb);
          `PFMSC_ADDR_GOE: goe <= merge(goe, w_data, w_strb);
          `PFMSC_ADDR_GIN: BRESP <= `PFMSC_RESP_OKAY;
          `PFMSC_ADDR_STRAP: BRESP <= `PFMSC_RESP_OKAY;
          default: BRESP <= `PFMSC_RESP_SLVERR;
        endcase
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= `PFMSC_RESP_OKAY;
    end else begin
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
        RVALID <= 1'b1;
        RRESP <= `PFMSC_RESP_OKAY;
        case (ar_idx)
          `PFMSC_ADDR_CTRL: RDATA <= ctrl;
          `PFMSC_ADDR_FUNC: RDATA <= func;
          `PFMSC_ADDR_GOUT: RDATA <= gout;
          `PFMSC_ADDR_GOE: RDATA <= goe;
          `PFMSC_ADDR_GIN: RDATA <= gpio_s;
          `PFMSC_ADDR_STRAP: RDATA <= {22'h0, pd_q, done, strap_bits};
          default: begin
            RDATA <= 32'h0;
            RRESP <= `PFMSC_RESP_SLVERR;
          end
        endcase
      end
      if (RVALID && RREADY) begin
        RVALID <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// file: bench/pfmsc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pfmsc_checker (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic FULL_POWERDOWN_N,
  input wire logic POWERDOWN,
  input wire logic STRAP_DONE,
  input wire logic REFCLK_40MHZ,
  input wire logic [1:0] HOST_IF_SEL,
  input wire logic FRONT_END_CTRL_LINE3,
  input wire logic FRONT_END_CTRL_LINE3_O,
  input wire logic FRONT_END_CTRL_LINE3_OE_N,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [1:0] BRESP,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  input wire logic [3:0] SD_DAT_IN,
  input wire logic [3:0] SD_DAT_PAD_I,
  input wire logic [31:0] GPIO_PAD_OE_N
);
  // ========================================
  // settle counter: sync chains still hold reset values just after release
  logic [2:0] settle_cnt;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) settle_cnt <= 3'h0;
    else if (settle_cnt != 3'h7) settle_cnt <= settle_cnt + 3'h1;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // ========================================
  // assertions
  pd_latency_a:
    assert property (settle_cnt == 3'h7 |-> POWERDOWN == !$past(FULL_POWERDOWN_N, 3)) else $error("power-down lag");
  strap_hold_a:
    assert property (STRAP_DONE && $past(STRAP_DONE) |-> $stable(HOST_IF_SEL) && $stable(REFCLK_40MHZ))
      else $error("strap changed");
  strap_release_a:
    assert property ($rose(STRAP_DONE) && !POWERDOWN |=> !FRONT_END_CTRL_LINE3_OE_N
      && FRONT_END_CTRL_LINE3_O == $past(FRONT_END_CTRL_LINE3)) else $error("line3 not released to function");
  pd_pads_a:
    assert property (POWERDOWN && $past(POWERDOWN) |-> &GPIO_PAD_OE_N[31:1]) else $error("pad driven in power-down");
  sd_pass_a:
    assert property (settle_cnt == 3'h7 |-> SD_DAT_IN == $past(SD_DAT_PAD_I, 3)) else $error("sdio input lag");
  write_resp_a:
    assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID) else $error("late write response");
  read_resp_a:
    assert property (ARVALID && ARREADY |=> RVALID && !ARREADY) else $error("late read data");
  bresp_hold_a:
    assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("write response dropped");
  rdata_hold_a:
    assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("read data dropped");
endmodule
bind pfmsc_top pfmsc_checker pfmsc_checker_inst (.*);
`default_nettype wire

// file: bench/pfmsc_board.sv
`timescale 1ns/1ps
`default_nettype none
module pfmsc_board (
  input wire logic pd_drv,
  input wire logic pd_val,
  input wire logic [3:0] strap_low,
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_val,
  input wire logic l3o,
  input wire logic l3oe_n,
  input wire logic l4o,
  input wire logic l4oe_n,
  input wire logic [31:0] go,
  input wire logic [31:0] goe_n,
  input wire logic [3:0] so,
  input wire logic [3:0] soe_n,
  output logic full_powerdown_n,
  output logic [1:0] boot,
  output logic l3i,
  output logic l4i,
  output logic [31:0] gi,
  output logic [3:0] si
);
  // ========================================
  // host pin and board pulls
  assign full_powerdown_n = pd_drv ? pd_val : 1'h0;
  assign boot = ~strap_low[1:0];
  assign l3i = !l3oe_n ? l3o : !strap_low[2];
  assign l4i = !l4oe_n ? l4o : !strap_low[3];
  // device wins a contention here, so a stray drive shows as a value error
  assign gi = (~goe_n & go) | (goe_n & ext_en & ext_val) | (goe_n & ~ext_en);
  assign si = (~soe_n & so) | soe_n;
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic CLOCK = 1'h0, SYS_RST = 1'h1, AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
  logic [7:0] AWADDR = '0, ARADDR = '0;
  logic [31:0] WDATA = '0, ext_en = '0, ext_val = '0, RDATA, GPIO_PAD_I, GPIO_PAD_O, GPIO_PAD_OE_N;
  logic [3:0] WSTRB = 4'hf, SD_DAT_OUT = '0, SD_DAT_OUT_EN = '0, strap_low = 4'h2;
  logic [3:0] SD_DAT_PAD_I, SD_DAT_PAD_O, SD_DAT_PAD_OE_N, SD_DAT_IN;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, REFCLK_40MHZ, STRAP_DONE, POWERDOWN, FULL_POWERDOWN_N;
  logic [1:0] BRESP, RRESP, HOST_BOOT_PAD, HOST_IF_SEL;
  logic FRONT_END_CTRL_LINE3_I, FRONT_END_CTRL_LINE3_O, FRONT_END_CTRL_LINE3_OE_N;
  logic FRONT_END_CTRL_LINE4_I, FRONT_END_CTRL_LINE4_O, FRONT_END_CTRL_LINE4_OE_N;
  logic FRONT_END_CTRL_LINE3 = 1'h0, FRONT_END_CTRL_LINE4 = 1'h0, SDIO_DATA2_READWAIT = 1'h0, SDIO_DATA1_IRQ = 1'h0;
  logic AUD_PCM_CLK = 1'h0, AUD_I2S_BCLK = 1'h0, pd_drv = 1'h0, pd_val = 1'h0;
  logic [9:0] cv = '0;
  wire JTAG_TDO, COEX_SERIAL_OUT, HOST_IRQ_OUT, RADIO_B_WAKE_OUT, RADIO_W_WAKE_OUT, COEX_GRANT_OUT, UART_TX;
  wire UART_RTS_N, AUD_SYNC_OUT, AUD_DOUT, JTAG_TDI, JTAG_TMS, JTAG_TCK, COEX_SERIAL_IN, COEX_OVERLAP_IN;
  wire RADIO_B_WAKE_IN, RADIO_W_WAKE_IN, COEX_PRIORITY_IN, COEX_REQUEST_IN, COEX_DIR_IN, UART_RX, UART_CTS_N;
  wire AUD_SYNC_IN, AUD_DIN, AUD_BCLK_IN, RADIO_B_RESET_IN, RADIO_W_RESET_IN;
  assign {JTAG_TDO, COEX_SERIAL_OUT, HOST_IRQ_OUT, RADIO_B_WAKE_OUT, RADIO_W_WAKE_OUT, COEX_GRANT_OUT, UART_TX,
    UART_RTS_N, AUD_SYNC_OUT, AUD_DOUT} = cv;
  wire [16:0] co = {JTAG_TDI, JTAG_TMS, JTAG_TCK, COEX_SERIAL_IN, COEX_OVERLAP_IN, RADIO_B_WAKE_IN,
    RADIO_W_WAKE_IN, COEX_PRIORITY_IN, COEX_REQUEST_IN, COEX_DIR_IN, UART_RX, UART_CTS_N, AUD_SYNC_IN,
    AUD_DIN, AUD_BCLK_IN, RADIO_B_RESET_IN, RADIO_W_RESET_IN};
  int op[10] = '{5, 7, 9, 11, 14, 17, 19, 21, 26, 31};
  int ip[17] = '{1, 2, 4, 6, 7, 8, 10, 12, 13, 15, 16, 18, 20, 25, 28, 29, 30};
  int fails = 0;
  int num_checks = 0;
  pfmsc_top pfmsc_top_inst (.*);
  pfmsc_board pfmsc_board_inst (.pd_drv(pd_drv), .pd_val(pd_val), .strap_low(strap_low), .ext_en(ext_en),
    .ext_val(ext_val), .l3o(FRONT_END_CTRL_LINE3_O), .l3oe_n(FRONT_END_CTRL_LINE3_OE_N),
    .l4o(FRONT_END_CTRL_LINE4_O), .l4oe_n(FRONT_END_CTRL_LINE4_OE_N), .go(GPIO_PAD_O), .goe_n(GPIO_PAD_OE_N),
    .so(SD_DAT_PAD_O), .soe_n(SD_DAT_PAD_OE_N), .full_powerdown_n(FULL_POWERDOWN_N), .boot(HOST_BOOT_PAD),
    .l3i(FRONT_END_CTRL_LINE3_I), .l4i(FRONT_END_CTRL_LINE4_I), .gi(GPIO_PAD_I), .si(SD_DAT_PAD_I));
  always #12.5 CLOCK = ~CLOCK;
  // ========================================
  // tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  task automatic chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ready offered with the request and held until the answer is sampled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    forever begin
      @(posedge CLOCK);
      if (AWREADY) AWVALID <= 1'h0;
      if (WREADY) WVALID <= 1'h0;
      if ((BVALID && BREADY) || n > 60) break;
      n++;
    end
    BREADY <= 1'h0;
    chk(BVALID === 1'h1 && BRESP === 2'h0, "write");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    forever begin
      @(posedge CLOCK);
      if (ARREADY) ARVALID <= 1'h0;
      if ((RVALID && RREADY) || n > 60) break;
      n++;
    end
    RREADY <= 1'h0;
    chk(RVALID === 1'h1 && RDATA === e && RRESP === r, "read");
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    while (STRAP_DONE !== 1'h1 && n < 100) begin
      @(posedge CLOCK);
      n++;
    end
    chk(STRAP_DONE === 1'h1, "strap capture");
  endtask
  initial begin
    #250000;
    fails++;
    report_and_stop();
  end
  // ========================================
  // tests
  initial begin
    cyc(5);
    SYS_RST <= 1'h0;
    cyc(10);
    chk(POWERDOWN === 1'h1 && STRAP_DONE === 1'h0, "undriven pin");
    rd(8'h00, 32'h41, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    pd_drv <= 1'h1;
    pd_val <= 1'h1;
    wait_done();
    chk(REFCLK_40MHZ === 1'h1 && HOST_IF_SEL === 2'h1, "straps");
    rd(8'h14, 32'h1fd, 2'h0);
    chk(FRONT_END_CTRL_LINE3_OE_N === 1'h0 && FRONT_END_CTRL_LINE3_O === 1'h0, "line3");
    strap_low <= 4'hf;
    cyc(10);
    chk(REFCLK_40MHZ === 1'h1 && HOST_IF_SEL === 2'h1, "strap hold");
    wr(8'h0c, 32'h800, 4'hf);
    cv <= '1;
    cyc(4);
    chk(GPIO_PAD_O[11] === 1'h0 && GPIO_PAD_OE_N[11] === 1'h0, "plain pad");
    wr(8'h08, 32'hffffffff, 4'h2);
    rd(8'h08, 32'hff00, 2'h0);
    wr(8'h0c, 32'h0, 4'hf);
    wr(8'h04, 32'hffffffff, 4'hf);
    wr(8'h00, 32'h55, 4'hf);
    AUD_PCM_CLK <= 1'h1;
    for (int k = 0; k < 10; k++) begin
      cv <= 10'h1 << k;
      cyc(4);
      for (int j = 0; j < 10; j++)
        chk(GPIO_PAD_O[op[j]] === (j == k) && GPIO_PAD_OE_N[op[j]] === 1'h0, "out pad");
    end
    chk(GPIO_PAD_OE_N[0] === 1'h1 && GPIO_PAD_O[3] === 1'h1, "crystal, pcm clock");
    wr(8'h00, 32'h5d, 4'hf);
    cyc(4);
    chk(GPIO_PAD_O[3] === 1'h0, "i2s clock");
    wr(8'h00, 32'h75, 4'hf);
    cyc(3);
    chk(GPIO_PAD_OE_N[0] === 1'h0 && GPIO_PAD_O[0] === 1'h1, "osc on");
    wr(8'h00, 32'h35, 4'hf);
    SD_DAT_OUT_EN <= 4'hf;
    SD_DAT_OUT <= 4'ha;
    cyc(3);
    chk(GPIO_PAD_O[0] === 1'h0 && SD_DAT_PAD_O === 4'ha && SD_DAT_PAD_OE_N === 4'h0, "osc off, sdio");
    SD_DAT_OUT_EN <= 4'h0;
    SDIO_DATA2_READWAIT <= 1'h1;
    wr(8'h00, 32'h43, 4'hf);
    cyc(3);
    chk(SD_DAT_PAD_OE_N[2] === 1'h0 && SD_DAT_PAD_O[2] === 1'h0, "read wait");
    SDIO_DATA1_IRQ <= 1'h1;
    wr(8'h00, 32'h40, 4'hf);
    cyc(3);
    chk(SD_DAT_PAD_OE_N[1] === 1'h0 && SD_DAT_PAD_O[1] === 1'h0 && SD_DAT_PAD_OE_N[3] === 1'h1, "1-bit");
    chk(GPIO_PAD_OE_N[4] === 1'h1 && GPIO_PAD_OE_N[7] === 1'h1, "peripheral audio");
    for (int k = 0; k < 17; k++) begin
      ext_en <= 32'h7215b5d6;
      ext_val <= 32'h1 << ip[k];
      cyc(6);
      chk(co === 17'h1 << k, "in pad");
    end
    pd_val <= 1'h0;
    strap_low <= 4'h4;
    cyc(10);
    chk(POWERDOWN === 1'h1 && STRAP_DONE === 1'h0, "power-down");
    pd_val <= 1'h1;
    wait_done();
    chk(REFCLK_40MHZ === 1'h0 && HOST_IF_SEL === 2'h3, "recapture");
    report_and_stop();
  end
endmodule
`default_nettype wire
